// [rtl/ltdo_observe.sv]
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
module ltdo_observe
  import ltdo_pkg::*;
#(
  parameter int unsigned LANES = 4,
  parameter int unsigned TS_COUNT_W = 8
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic state_change_i,
  input wire logic idle_state_i,
  input wire ltdo_rx_evt_t rx_evt_i,
  input wire ltdo_width_t width_i,
  input wire logic [1:0] logical_lane0_i,
  input wire logic [11:0] deskew_fill_i,
  input wire logic [3:0] deskew_overflow_i,
  input wire ltdo_pcs_t pcs_i,
  input wire logic generic_phy_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  output logic irq_o,
  output logic retrain_req_o,
  output logic [LTDO_BUS_W-1:0] debug_bus_o
);

  if (LANES != 4 || TS_COUNT_W != 8) begin : g_param_check
    $error("ltdo_observe supports four lanes and an 8-bit set counter only");
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [7:0] lane_field(input logic [3:0] flags);
    lane_field = {4'h0, flags};
  endfunction : lane_field

  function automatic logic [3:0] width_code(input ltdo_width_t w);
    case (w)
      LTDO_WIDTH_ONE: width_code = LTDO_WIDTH_X1;
      LTDO_WIDTH_TWO: width_code = LTDO_WIDTH_X2;
      default: width_code = LTDO_WIDTH_X4;
    endcase
  endfunction : width_code

  function automatic logic reg_hit(input logic strobe, input logic [3:0] addr,
      input logic [3:0] offset);
    reg_hit = strobe && (addr == offset);
  endfunction : reg_hit

  // ----------------------------------------
  // Training flags and counters
  // ----------------------------------------
  logic [3:0] run_reg [4];
  logic [3:0] run_next [4];
  logic [3:0] idle_run_reg, idle_run_next;
  logic [3:0] idle_os_reg, idle_os_next;
  logic [3:0] link_pad_reg, link_pad_next;
  logic [3:0] lane_pad_reg, lane_pad_next;
  logic [7:0] ts_count_reg, ts_count_next;
  logic [3:0] deskew_err_reg, deskew_err_next;
  logic retrain_reg, retrain_next;
  logic [3:0] irq_stat_reg, irq_stat_next;
  logic [3:0] irq_en_reg, irq_en_next;
  logic irq_reg, irq_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [LTDO_BUS_W-1:0] bus_reg, bus_next;
  logic [3:0] evt;

  always_comb begin
    idle_run_next = idle_run_reg;
    idle_os_next = idle_os_reg;
    link_pad_next = link_pad_reg;
    lane_pad_next = lane_pad_reg;
    ts_count_next = ts_count_reg;
    for (int i = 0; i < 4; i++) begin
      run_next[i] = run_reg[i];
    end
    if (state_change_i) begin
      // An idle ordered set or pad flag in the entry cycle belongs to the new state, so it survives the clear.
      idle_run_next = 4'h0;
      idle_os_next = rx_evt_i.idle_os;
      link_pad_next = rx_evt_i.ts_valid & rx_evt_i.ts_link_pad;
      lane_pad_next = rx_evt_i.ts_valid & rx_evt_i.ts_lane_pad;
      ts_count_next = LTDO_TS_COUNT_RST;
      for (int i = 0; i < 4; i++) begin
        run_next[i] = 4'h0;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (!rx_evt_i.idle_symbol[i] || !idle_state_i) begin
          run_next[i] = 4'h0;
        end else if (run_reg[i] != 4'(LTDO_IDLE_RUN_LEN)) begin
          run_next[i] = run_reg[i] + 4'h1;
        end
        idle_run_next[i] = (run_next[i] == 4'(LTDO_IDLE_RUN_LEN));
        if (rx_evt_i.idle_os[i]) begin
          idle_os_next[i] = 1'b1;
        end
        if (rx_evt_i.ts_valid[i]) begin
          link_pad_next[i] = rx_evt_i.ts_link_pad[i];
          lane_pad_next[i] = rx_evt_i.ts_lane_pad[i];
        end
      end
      if (rx_evt_i.ts_valid[logical_lane0_i]) begin
        if (rx_evt_i.ts_same[logical_lane0_i]) begin
          ts_count_next = ts_count_reg + 8'h01;
        end else begin
          ts_count_next = LTDO_TS_COUNT_RST;
        end
      end
    end
  end

  // ----------------------------------------
  // Deskew errors, interrupts and registers
  // ----------------------------------------
  always_comb begin
    evt = deskew_overflow_i & ~deskew_err_reg;
    deskew_err_next = deskew_err_reg | deskew_overflow_i;
    retrain_next = |deskew_overflow_i;
    if (state_change_i && !(|deskew_overflow_i)) begin
      deskew_err_next = 4'h0;
    end
    irq_en_next = irq_en_reg;
    irq_stat_next = irq_stat_reg;
    rdata_next = 32'h0;
    if (reg_hit(reg_wr_i, reg_addr_i, LTDO_ADDR_CLEAR)) begin
      irq_stat_next = irq_stat_reg & ~reg_wdata_i[3:0];
    end else if (reg_hit(reg_wr_i, reg_addr_i, LTDO_ADDR_ENABLE)) begin
      irq_en_next = reg_wdata_i[3:0];
    end
    // Set after clear so a new overflow in the clear cycle is kept.
    irq_stat_next = irq_stat_next | evt;
    if (reg_hit(reg_rd_i, reg_addr_i, LTDO_ADDR_STATUS)) begin
      rdata_next = {28'h0, irq_stat_reg};
    end else if (reg_hit(reg_rd_i, reg_addr_i, LTDO_ADDR_ENABLE)) begin
      rdata_next = {28'h0, irq_en_reg};
    end else if (reg_hit(reg_rd_i, reg_addr_i, LTDO_ADDR_TSCOUNT)) begin
      rdata_next = {24'h0, ts_count_reg};
    end
    irq_next = |(irq_stat_next & irq_en_next);
  end

  // ----------------------------------------
  // Observation bus assembly
  // ----------------------------------------
  always_comb begin
    bus_next = '0;
    bus_next[LTDO_IDLE_RUN_POS +: 8] = lane_field(idle_run_next);
    bus_next[LTDO_IDLE_OS_POS +: 8] = lane_field(idle_os_next);
    bus_next[LTDO_LINK_PAD_POS +: 8] = lane_field(link_pad_next);
    bus_next[LTDO_LANE_PAD_POS +: 8] = lane_field(lane_pad_next);
    bus_next[LTDO_TS_COUNT_POS +: 8] = ts_count_next;
    bus_next[LTDO_WIDTH_POS +: 4] = width_code(width_i);
    bus_next[LTDO_DESKEW_POS +: 12] = deskew_fill_i;
    bus_next[LTDO_DESKEW_ERR_POS +: 8] = lane_field(deskew_err_next);
    // The elastic fill is only forced to zero; the generic PHY has no such counters.
    if (!generic_phy_i) begin
      bus_next[LTDO_EFILL0_POS +: 4] = pcs_i.elastic_fill_lane0;
      bus_next[LTDO_EFILL1_POS +: 4] = pcs_i.elastic_fill_lane1;
    end
    bus_next[LTDO_STATUS0_POS +: 3] = pcs_i.rx_status_code_lane0;
    bus_next[LTDO_INVERT0_POS] = pcs_i.rx_invert_request_lane0;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < 4; i++) begin
        run_reg[i] <= 4'h0;
      end
      idle_run_reg <= 4'h0;
      idle_os_reg <= 4'h0;
      link_pad_reg <= 4'h0;
      lane_pad_reg <= 4'h0;
      ts_count_reg <= LTDO_TS_COUNT_RST;
    end else if (clk_en_i) begin
      for (int i = 0; i < 4; i++) begin
        run_reg[i] <= run_next[i];
      end
      idle_run_reg <= idle_run_next;
      idle_os_reg <= idle_os_next;
      link_pad_reg <= link_pad_next;
      lane_pad_reg <= lane_pad_next;
      ts_count_reg <= ts_count_next;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      deskew_err_reg <= 4'h0;
      retrain_reg <= 1'b0;
      irq_stat_reg <= 4'h0;
      irq_en_reg <= 4'h0;
      irq_reg <= 1'b0;
      rdata_reg <= 32'h0;
    end else if (clk_en_i) begin
      deskew_err_reg <= deskew_err_next;
      retrain_reg <= retrain_next;
      irq_stat_reg <= irq_stat_next;
      irq_en_reg <= irq_en_next;
      irq_reg <= irq_next;
      rdata_reg <= rdata_next;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      bus_reg <= '0;
    end else if (clk_en_i) begin
      bus_reg <= bus_next;
    end
  end

  assign reg_rdata_o = rdata_reg;
  assign irq_o = irq_reg;
  assign retrain_req_o = retrain_reg;
  assign debug_bus_o = bus_reg;

endmodule : ltdo_observe

// [rtl/ltdo_pkg.sv]
package ltdo_pkg;

  // ----------------------------------------
  // Field positions on the observation bus
  // ----------------------------------------
  localparam int unsigned LTDO_BUS_LO = 368;
  localparam int unsigned LTDO_BUS_W = 92;
  localparam int unsigned LTDO_IDLE_RUN_POS = 0;
  localparam int unsigned LTDO_IDLE_OS_POS = 8;
  localparam int unsigned LTDO_LINK_PAD_POS = 16;
  localparam int unsigned LTDO_LANE_PAD_POS = 24;
  localparam int unsigned LTDO_TS_COUNT_POS = 32;
  localparam int unsigned LTDO_WIDTH_POS = 40;
  localparam int unsigned LTDO_LANE_ORDER_POS = 44;
  localparam int unsigned LTDO_DESKEW_POS = 48;
  localparam int unsigned LTDO_RSVD_POS = 60;
  localparam int unsigned LTDO_DESKEW_ERR_POS = 72;
  localparam int unsigned LTDO_EFILL0_POS = 80;
  localparam int unsigned LTDO_STATUS0_POS = 84;
  localparam int unsigned LTDO_INVERT0_POS = 87;
  localparam int unsigned LTDO_EFILL1_POS = 88;

  // ----------------------------------------
  // Codes and reset values
  // ----------------------------------------
  localparam logic [3:0] LTDO_WIDTH_X1 = 4'h1;
  localparam logic [3:0] LTDO_WIDTH_X2 = 4'h2;
  localparam logic [3:0] LTDO_WIDTH_X4 = 4'h4;
  localparam logic [2:0] LTDO_RXST_OK = 3'h0;
  localparam logic [2:0] LTDO_RXST_SKP_ADD = 3'h1;
  localparam logic [2:0] LTDO_RXST_SKP_DEL = 3'h2;
  localparam logic [2:0] LTDO_RXST_DETECT = 3'h3;
  localparam logic [2:0] LTDO_RXST_DECODE = 3'h4;
  localparam logic [2:0] LTDO_RXST_EB_OVF = 3'h5;
  localparam logic [2:0] LTDO_RXST_EB_UNF = 3'h6;
  localparam logic [2:0] LTDO_RXST_DISP = 3'h7;
  localparam logic [7:0] LTDO_TS_COUNT_RST = 8'h00;
  localparam int unsigned LTDO_IDLE_RUN_LEN = 8;

  typedef enum logic [1:0] {
    LTDO_WIDTH_ONE,
    LTDO_WIDTH_TWO,
    LTDO_WIDTH_FOUR
  } ltdo_width_t;

  // Per-lane receive events from the training logic, one-cycle pulses.
  typedef struct packed {
    logic [3:0] idle_symbol;
    logic [3:0] idle_os;
    logic [3:0] ts_valid;
    logic [3:0] ts_link_pad;
    logic [3:0] ts_lane_pad;
    logic [3:0] ts_same;
  } ltdo_rx_evt_t;

  // Lane-0/1 coding sublayer view.
  typedef struct packed {
    logic [3:0] elastic_fill_lane0;
    logic [3:0] elastic_fill_lane1;
    logic [2:0] rx_status_code_lane0;
    logic rx_invert_request_lane0;
  } ltdo_pcs_t;

  // Interrupt and set-count register offsets.
  localparam logic [3:0] LTDO_ADDR_STATUS = 4'h0;
  localparam logic [3:0] LTDO_ADDR_CLEAR = 4'h4;
  localparam logic [3:0] LTDO_ADDR_ENABLE = 4'h8;
  localparam logic [3:0] LTDO_ADDR_TSCOUNT = 4'hc;
  localparam int unsigned LTDO_IRQ_W = 4;

endpackage : ltdo_pkg

// [testbench/ltdo_observe_props.sv]
`timescale 1ns/100ps
// ----------
// Bus and retrain checks
// ----------
module ltdo_observe_props
  import ltdo_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic state_change_i,
  input wire ltdo_rx_evt_t rx_evt_i,
  input wire ltdo_width_t width_i,
  input wire logic [1:0] logical_lane0_i,
  input wire logic [11:0] deskew_fill_i,
  input wire logic [3:0] deskew_overflow_i,
  input wire ltdo_pcs_t pcs_i,
  input wire logic generic_phy_i,
  input wire logic retrain_req_o,
  input wire logic [LTDO_BUS_W-1:0] debug_bus_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  a_flag_upper:
    assert property ({debug_bus_o[79:76], debug_bus_o[31:28], debug_bus_o[23:20],
      debug_bus_o[15:12], debug_bus_o[7:4]} == 20'h00000) else $error("upper bits set");
  a_rsvd_zero:
    assert property ({debug_bus_o[71:60], debug_bus_o[47:44]} == 16'h0000) else $error("rsvd");
  a_width_code:
    assert property (rst_n_i && clk_en_i |=> debug_bus_o[43:40] ==
      (($past(width_i) == LTDO_WIDTH_ONE) ? LTDO_WIDTH_X1 :
      ($past(width_i) == LTDO_WIDTH_TWO) ? LTDO_WIDTH_X2 : LTDO_WIDTH_X4))
      else $error("width");
  a_deskew_fill:
    assert property (rst_n_i && clk_en_i |=> debug_bus_o[59:48] == $past(deskew_fill_i))
      else $error("fill");
  a_idle_os_set:
    assert property (rst_n_i && clk_en_i |=> (debug_bus_o[11:8] & $past(rx_evt_i.idle_os)) ==
      $past(rx_evt_i.idle_os)) else $error("idle os");
  a_elastic_gate:
    assert property (rst_n_i && clk_en_i |=> {debug_bus_o[91:88], debug_bus_o[83:80]} ==
      ($past(generic_phy_i) ? 8'h00 : {$past(pcs_i.elastic_fill_lane1),
      $past(pcs_i.elastic_fill_lane0)})) else $error("elastic");
  a_status_copy:
    assert property (rst_n_i && clk_en_i |=> debug_bus_o[87:84] ==
      {$past(pcs_i.rx_invert_request_lane0), $past(pcs_i.rx_status_code_lane0)})
      else $error("status");
  a_retrain_pulse:
    assert property (rst_n_i && clk_en_i |=> retrain_req_o == (|$past(deskew_overflow_i)))
      else $error("retrain");
  a_err_set:
    assert property (rst_n_i && clk_en_i |=> (debug_bus_o[75:72] & $past(deskew_overflow_i)) ==
      $past(deskew_overflow_i)) else $error("deskew err");
  a_ts_count:
    assert property (rst_n_i && clk_en_i && !state_change_i &&
      rx_evt_i.ts_valid[logical_lane0_i] && rx_evt_i.ts_same[logical_lane0_i] |=>
      debug_bus_o[39:32] == 8'($past(debug_bus_o[39:32]) + 8'h01)) else $error("ts count");
endmodule : ltdo_observe_props

bind ltdo_observe ltdo_observe_props u_ltdo_observe_props (.sys_clk_i, .rst_n_i, .clk_en_i,
  .state_change_i, .rx_evt_i, .width_i, .logical_lane0_i, .deskew_fill_i, .deskew_overflow_i,
  .pcs_i, .generic_phy_i, .retrain_req_o, .debug_bus_o);

// [testbench/ltdo_bus_sampler.sv]
`timescale 1ns/100ps
// ----------
// Debug sampler
// ----------
module ltdo_bus_sampler (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic retrain_i,
  output logic [7:0] retrain_cnt_o
);
  // Counting high cycles rather than edges shows a request held too long.
  logic [7:0] cnt_reg, cnt_next;
  always_comb begin
    cnt_next = cnt_reg + 8'(retrain_i);
  end
  always_ff @(posedge sys_clk_i) begin
    cnt_reg <= rst_n_i ? cnt_next : 8'h00;
  end
  assign retrain_cnt_o = cnt_reg;
endmodule : ltdo_bus_sampler

// [testbench/ltdo_observe_test.sv]
`timescale 1ns/100ps
// ----------
// Bench top
// ----------
module ltdo_observe_test
  import ltdo_pkg::*;
;
  logic sys_clk_i = 1'b0, rst_n_i = 1'b0, clk_en_i = 1'b1, state_change_i = 1'b0;
  logic idle_state_i = 1'b0, generic_phy_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  ltdo_rx_evt_t rx_evt_i = '0;
  ltdo_width_t width_i = LTDO_WIDTH_ONE;
  ltdo_pcs_t pcs_i = '0;
  logic [1:0] logical_lane0_i = 2'h0;
  logic [11:0] deskew_fill_i = 12'h000;
  logic [3:0] deskew_overflow_i = 4'h0, reg_addr_i = 4'h0;
  logic [31:0] reg_wdata_i = 32'h00000000, reg_rdata_o;
  logic irq_o, retrain_req_o;
  logic [LTDO_BUS_W-1:0] debug_bus_o;
  logic [7:0] retrain_cnt;
  logic [3:0] wexp [3] = '{LTDO_WIDTH_X1, LTDO_WIDTH_X2, LTDO_WIDTH_X4};
  int error_cnt = 0, checked = 0;
  always #5 sys_clk_i = ~sys_clk_i;
  ltdo_observe u_ltdo_observe (.sys_clk_i, .rst_n_i, .clk_en_i, .state_change_i, .idle_state_i,
    .rx_evt_i, .width_i, .logical_lane0_i, .deskew_fill_i, .deskew_overflow_i, .pcs_i,
    .generic_phy_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .irq_o,
    .retrain_req_o, .debug_bus_o);
  ltdo_bus_sampler u_ltdo_bus_sampler (.sys_clk_i, .rst_n_i, .retrain_i(retrain_req_o),
    .retrain_cnt_o(retrain_cnt));
  task automatic chk(input string nm, input logic [LTDO_BUS_W-1:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic ck(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask : ck
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    ck(1);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    ck(1);
    reg_wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    ck(1);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    ck(1);
    reg_rd_i <= 1'b0;
    #1 chk("rdata", reg_rdata_o, e);
  endtask : rd
  task automatic give_verdict();
    if (error_cnt == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (5000) @(posedge sys_clk_i);
    error_cnt++;
    give_verdict();
  end
  initial begin
    ck(5);
    rst_n_i <= 1'b1;
    #1 chk("reset_bus", debug_bus_o, '0);
    chk("reset_out", {irq_o, retrain_req_o, reg_rdata_o}, '0);
    foreach (wexp[i]) begin
      ck(1);
      width_i <= ltdo_width_t'(i);
      ck(1);
      #1 chk("width", debug_bus_o[43:40], wexp[i]);
    end
    ck(1);
    clk_en_i <= 1'b0;
    width_i <= LTDO_WIDTH_ONE;
    ck(2);
    #1 chk("freeze", debug_bus_o[43:40], LTDO_WIDTH_X4);
    ck(1);
    clk_en_i <= 1'b1;
    ck(1);
    #1 chk("thaw", debug_bus_o[43:40], LTDO_WIDTH_X1);
    for (int c = 0; c < 8; c++) begin
      ck(1);
      deskew_fill_i <= {3'(7 - c), 3'(c + 2), 3'(c + 1), 3'(c)};
      pcs_i <= '{4'(c + 8), 4'(c), 3'(c), c[1]};
      generic_phy_i <= c[0];
      ck(1);
      #1 chk("deskew", debug_bus_o[59:48], {3'(7 - c), 3'(c + 2), 3'(c + 1), 3'(c)});
      chk("efill0", debug_bus_o[83:80], c[0] ? 4'h0 : 4'(c + 8));
      chk("efill1", debug_bus_o[91:88], c[0] ? 4'h0 : 4'(c));
      chk("status", debug_bus_o[87:84], {c[1], 3'(c)});
    end
    ck(1);
    idle_state_i <= 1'b1;
    rx_evt_i <= '{4'h1, 4'h2, 4'h8, 4'h8, 4'h0, 4'h0};
    ck(7);
    #1 chk("idle7", debug_bus_o[31:0], 32'h00080200);
    ck(1);
    #1 chk("idle8", debug_bus_o[7:0], 8'h01);
    ck(1);
    rx_evt_i <= '0;
    state_change_i <= 1'b1;
    ck(1);
    state_change_i <= 1'b0;
    logical_lane0_i <= 2'h2;
    rx_evt_i.ts_same <= 4'h4;
    rx_evt_i.ts_valid <= 4'h4;
    #1 chk("flags", debug_bus_o[39:0], '0);
    ck(255);
    #1 chk("tscount", debug_bus_o[39:32], 8'hff);
    ck(1);
    #1 chk("tswrap", debug_bus_o[39:32], 8'h00);
    ck(1);
    rx_evt_i <= '0;
    deskew_overflow_i <= 4'h2;
    ck(1);
    deskew_overflow_i <= 4'h0;
    rd(LTDO_ADDR_STATUS, 32'h2);
    chk("deskew_err", debug_bus_o[79:72], 8'h02);
    chk("irq_off", irq_o, 1'b0);
    wr(LTDO_ADDR_ENABLE, 32'h2);
    wr(LTDO_ADDR_STATUS, 32'h0);
    rd(LTDO_ADDR_ENABLE, 32'h2);
    chk("irq_on", irq_o, 1'b1);
    rd(LTDO_ADDR_STATUS, 32'h2);
    wr(LTDO_ADDR_CLEAR, 32'h2);
    rd(LTDO_ADDR_STATUS, 32'h0);
    rd(4'h1, 32'h0);
    rd(LTDO_ADDR_CLEAR, 32'h0);
    rd(LTDO_ADDR_TSCOUNT, 32'h1);
    chk("irq_clr", irq_o, 1'b0);
    chk("retrain", retrain_cnt, 8'h01);
    ck(1);
    state_change_i <= 1'b1;
    ck(1);
    state_change_i <= 1'b0;
    #1 chk("err_clr", debug_bus_o[79:72], 8'h00);
    ck(1);
    rst_n_i <= 1'b0;
    ck(1);
    rst_n_i <= 1'b1;
    #1 chk("rerst_bus", debug_bus_o, '0);
    rd(LTDO_ADDR_ENABLE, 32'h0);
    chk("rerst_irq", irq_o, 1'b0);
    give_verdict();
  end
endmodule : ltdo_observe_test
